// >>> common/egs_link_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 250 MHz clock and word-aligned AXI4-Lite byte addresses
`ifndef EGS_LINK_REGS_SVH
`define EGS_LINK_REGS_SVH
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_MASK 8'h08
`define OFS_READINGS 8'h0c
`define OFS_STAT_A 8'h10
`define OFS_STAT_B 8'h14
`define OFS_LINK 8'h18
// Control fields
`define CTRL_HEATER 0
`define CTRL_RESTART 1
// Status and mask fields
`define EV_RESULT 0
`define EV_RX_TIMEOUT 1
`define EV_TX_TIMEOUT 2
`define EV_WIDTH 3
`define CTRL_RESET 32'h0000_0000
`define MASK_RESET 3'h0
// Frame identifiers, 29-bit extended
`define CMD_FRAME_ID 29'h18fedf00
`define REPORT_FRAME_ID 29'h18f00f52
// Timing
`define CLK_KHZ 250000
`define BIT_RATE_KBPS 250
`define BIT_DIV (`CLK_KHZ / `BIT_RATE_KBPS)
`define RX_TIMEOUT_MS 100
`define RX_TIMEOUT_MIN_MS 50
`define RX_TIMEOUT_CYC (`RX_TIMEOUT_MS * `CLK_KHZ)
`define TX_TIMEOUT_MS 0
`define TX_TIMEOUT_MAX_MS 10
`define TX_TIMEOUT_CYC ((`TX_TIMEOUT_MS * `CLK_KHZ) > 0 ? (`TX_TIMEOUT_MS * `CLK_KHZ) : 1)
`define TX_TIMEOUT_MAX_CYC (`TX_TIMEOUT_MAX_MS * `CLK_KHZ)
`define CMD_PERIOD_MS 50
`define CMD_PERIOD_CYC (`CMD_PERIOD_MS * `CLK_KHZ)
`endif

// >>> common/egs_link_pkg.sv
// Types shared by the sensor link modules
// Assumes nothing beyond a SystemVerilog compiler
package egs_link_pkg;
  // Heater command code carried in command byte 0
  typedef enum logic [7:0] {
    HEATER_PREHEAT = 8'h00,
    HEATER_ON = 8'h01
  } heater_cmd_type;
  // Transmit sequencer states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_WAIT = 2'b01
  } tx_state_type;
  // AXI response codes
  typedef enum logic [1:0] {
    RESP_OKAY = 2'b00,
    RESP_SLVERR = 2'b10
  } resp_type;
endpackage

// >>> common/sensor_result_if.sv
// Extracted sensor results passed from the frame parser to the link core
// Assumes one clock domain shared by both ends
`timescale 1ns/1ps
interface sensor_result_if;
  logic new_frame; // One-cycle pulse per accepted report frame
  logic [15:0] nox_raw; // Raw nitrogen-oxide count
  logic [15:0] o2_raw; // Raw oxygen count
  logic [63:0] stat; // Eight 8-bit statuses
  modport producer (output new_frame, nox_raw, o2_raw, stat);
  modport consumer (input new_frame, nox_raw, o2_raw, stat);
endinterface

// >>> logic/report_parser.sv
// Report frame parser: filters on identifier and unpacks readings
// Assumes frames arrive as one-cycle valid beats synchronous to clk
`timescale 1ns/1ps
`include "egs_link_regs.svh"
module report_parser #(
  parameter int NOX_BYTE = 0, // Byte of the nitrogen-oxide count, low byte first
  parameter int O2_BYTE = 2, // Byte of the oxygen count, low byte first
  parameter int STAT_BIT = 32 // First of eight 2-bit status fields
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [28:0] rx_id,
  input wire logic rx_ext,
  input wire logic [63:0] rx_data,
  sensor_result_if.producer res
);
  // Field positions must lie inside the eight data bytes
  initial begin
    if (NOX_BYTE < 0 || NOX_BYTE > 6 || O2_BYTE < 0 || O2_BYTE > 6 ||
        STAT_BIT < 0 || STAT_BIT > 48) begin
      $error("report_parser: field offset outside frame");
    end
  end
  // Only the report identifier carries result data
  wire match = rx_valid && rx_ext && (rx_id == `REPORT_FRAME_ID);
  wire [15:0] nox_field = rx_data[NOX_BYTE*8 +: 16];
  wire [15:0] o2_field = rx_data[O2_BYTE*8 +: 16];
  wire [63:0] stat_field;
  // Each status widens a 2-bit field to a byte
  for (genvar i = 0; i < 8; i++) begin : g_stat
    assign stat_field[i*8 +: 8] = {6'h00, rx_data[STAT_BIT + 2*i +: 2]};
  end
  // Capture readings on a matching frame
  always_ff @(posedge clk) begin
    if (rst) begin
      res.new_frame <= 1'b0;
      res.nox_raw <= 16'h0000;
      res.o2_raw <= 16'h0000;
      res.stat <= 64'h0;
    end else begin
      res.new_frame <= match;
      if (match) begin
        res.nox_raw <= nox_field;
        res.o2_raw <= o2_field;
        res.stat <= stat_field;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_id_filter_drop: assert property (rx_valid && rx_id != `REPORT_FRAME_ID |=> !res.new_frame)
    else $error("foreign frame accepted");
  a_nox_capture: assert property (match |=> res.nox_raw == $past(nox_field))
    else $error("nitrogen-oxide count not captured");
  a_o2_capture: assert property (match |=> res.o2_raw == $past(o2_field))
    else $error("oxygen count not captured");
endmodule

// >>> logic/exhaust_gas_sensor_can_link.sv
// Exhaust gas sensor link core: command frames, report capture, AXI4-Lite registers
// Assumes a frame-level bus controller on the TX/RX ports and a 250 MHz REF_CLK
//
// What this block does
// - Bus bit-rate enable runs at 250 kbps
// - Receive timeout 100 ms, above 50 ms
// - Transmit timeout below 10 ms, default minimal
// - Every incoming frame is accepted from the bus
// - Command frames use fixed extended command identifier
// - Results taken only from report identifier frames
// - Heater request true asks heater on
// - Heater request false asks preheat 80-120 C
// - Payload presented only while transmit strobe high
// - Report 8-bit supply status
// - Report 8-bit sensor temperature status
// - Report nitrogen-oxide and oxygen validity statuses
// - Report 8-bit heater phase status
// - Report heater, nitrogen-oxide, oxygen wiring faults
// - Host restart resets the bus channel
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "egs_link_regs.svh"
module exhaust_gas_sensor_can_link #(
  parameter int RX_TIMEOUT_CYC = `RX_TIMEOUT_CYC, // Report silence limit
  parameter int TX_TIMEOUT_CYC = `TX_TIMEOUT_CYC, // Command acceptance limit
  parameter int CMD_PERIOD_CYC = `CMD_PERIOD_CYC, // Command repeat interval
  parameter int NOX_BYTE = 0, // Byte of nitrogen-oxide count
  parameter int O2_BYTE = 2, // Byte of oxygen count
  parameter int STAT_BIT = 32 // First status field bit
) (
  input wire logic REF_CLK,
  input wire logic RST,
  // AXI4-Lite slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Frame-level bus controller
  output logic BIT_TICK,
  output logic CHAN_RESTART,
  output logic TX_STROBE,
  input wire logic TX_READY,
  output logic [28:0] TX_ID,
  output logic TX_EXT,
  output logic [3:0] TX_DLC,
  output logic [63:0] TX_DATA,
  input wire logic RX_VALID,
  output logic RX_READY,
  input wire logic [28:0] RX_ID,
  input wire logic RX_EXT,
  input wire logic [63:0] RX_DATA,
  // Interrupt
  output logic IRQ
);
  localparam int BIT_DIV = `BIT_DIV;
  // Refuse timings the sensor link cannot work with
  initial begin
    if (RX_TIMEOUT_CYC < 1 || TX_TIMEOUT_CYC < 1 || CMD_PERIOD_CYC < 2) begin
      $error("exhaust_gas_sensor_can_link: timing parameter too small");
    end
    if (TX_TIMEOUT_CYC >= `TX_TIMEOUT_MAX_CYC) begin
      $error("exhaust_gas_sensor_can_link: transmit timeout too long");
    end
  end

  sensor_result_if res ();

  // Report frame unpacking
  report_parser #(
    .NOX_BYTE(NOX_BYTE),
    .O2_BYTE(O2_BYTE),
    .STAT_BIT(STAT_BIT)
  ) u_parser (
    .clk(REF_CLK),
    .rst(RST),
    .rx_valid(RX_VALID),
    .rx_id(RX_ID),
    .rx_ext(RX_EXT),
    .rx_data(RX_DATA),
    .res(res)
  );

  // ---------------- AXI4-Lite write path ----------------
  logic aw_full_reg; // Write address held
  logic [7:0] aw_addr_reg;
  logic w_full_reg; // Write data held
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic bresp_err_reg;
  logic [31:0] ctrl_reg; // Control register
  logic [`EV_WIDTH-1:0] sts_reg; // Sticky event bits
  logic [`EV_WIDTH-1:0] mask_reg; // Interrupt enables
  logic restart_reg; // One-cycle channel restart

  // Address and data are taken independently, one write in flight
  assign S_AXI_AWREADY = !aw_full_reg && !bvalid_reg;
  assign S_AXI_WREADY = !w_full_reg && !bvalid_reg;
  wire wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
  wire [31:0] lane_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                           {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  wire [31:0] wr_bits = w_data_reg & lane_mask;
  wire wr_ctrl = wr_go && aw_addr_reg == `OFS_CTRL;
  wire wr_sts = wr_go && aw_addr_reg == `OFS_STATUS;
  wire wr_mask = wr_go && aw_addr_reg == `OFS_MASK;
  wire wr_known = wr_ctrl || wr_sts || wr_mask ||
                  aw_addr_reg == `OFS_READINGS || aw_addr_reg == `OFS_STAT_A ||
                  aw_addr_reg == `OFS_STAT_B || aw_addr_reg == `OFS_LINK;
  wire [31:0] ctrl_next = (ctrl_reg & ~lane_mask) | (wr_bits & 32'h0000_0001);
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_err_reg ? egs_link_pkg::RESP_SLVERR : egs_link_pkg::RESP_OKAY;

  // Write channel capture and response
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_err_reg <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_err_reg <= !wr_known; // Unmapped address
      end else if (S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Control register; restart bit is a pulse, never stored
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_reg <= `CTRL_RESET;
      restart_reg <= 1'b0;
      mask_reg <= `MASK_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= ctrl_next;
      end
      restart_reg <= wr_ctrl && wr_bits[`CTRL_RESTART];
      if (wr_mask) begin
        mask_reg <= wr_bits[`EV_WIDTH-1:0];
      end
    end
  end
  assign CHAN_RESTART = restart_reg;
  wire heater_req = ctrl_reg[`CTRL_HEATER];

  // ---------------- Bit-rate enable ----------------
  logic [9:0] bit_cnt_reg;
  wire bit_wrap = bit_cnt_reg == 10'(BIT_DIV - 1);
  // Divides REF_CLK to the 250 kbps bit enable
  always_ff @(posedge REF_CLK) begin
    if (RST || restart_reg) begin
      bit_cnt_reg <= 10'h000;
    end else begin
      bit_cnt_reg <= bit_wrap ? 10'h000 : bit_cnt_reg + 10'h001;
    end
  end
  assign BIT_TICK = bit_wrap;

  // ---------------- Command transmit ----------------
  egs_link_pkg::tx_state_type tx_state_reg;
  logic [31:0] period_cnt_reg; // Command repeat timer
  logic [31:0] tx_wait_reg; // Cycles strobe has waited
  logic heater_sent_reg; // Heater request last sent
  logic [7:0] tx_code_reg;
  wire period_due = period_cnt_reg == 32'(CMD_PERIOD_CYC - 1);
  wire heater_change = heater_req != heater_sent_reg;
  wire tx_launch = tx_state_reg == egs_link_pkg::TX_IDLE && (period_due || heater_change);
  wire tx_pend = tx_state_reg == egs_link_pkg::TX_WAIT;
  wire tx_done = tx_pend && TX_READY;
  wire tx_expire = tx_pend && !TX_READY && tx_wait_reg == 32'(TX_TIMEOUT_CYC - 1);
  wire [7:0] heater_code = heater_req ? 8'(egs_link_pkg::HEATER_ON)
                                      : 8'(egs_link_pkg::HEATER_PREHEAT);

  // Repeat timer restarts on each launch
  always_ff @(posedge REF_CLK) begin
    if (RST || restart_reg || tx_launch) begin
      period_cnt_reg <= 32'h0;
    end else if (!period_due) begin
      period_cnt_reg <= period_cnt_reg + 32'h1;
    end
  end

  // Transmit sequencer: launch, wait for acceptance, drop on timeout
  always_ff @(posedge REF_CLK) begin
    if (RST || restart_reg) begin
      tx_state_reg <= egs_link_pkg::TX_IDLE;
      tx_wait_reg <= 32'h0;
      heater_sent_reg <= 1'b0;
      tx_code_reg <= 8'h00;
    end else begin
      case (tx_state_reg)
        egs_link_pkg::TX_IDLE: begin
          tx_wait_reg <= 32'h0;
          if (tx_launch) begin
            tx_state_reg <= egs_link_pkg::TX_WAIT;
            heater_sent_reg <= heater_req;
            tx_code_reg <= heater_code;
          end
        end
        egs_link_pkg::TX_WAIT: begin
          if (tx_done || tx_expire) begin
            tx_state_reg <= egs_link_pkg::TX_IDLE;
            tx_code_reg <= 8'h00;
          end else begin
            tx_wait_reg <= tx_wait_reg + 32'h1;
          end
        end
        default: begin
          tx_state_reg <= egs_link_pkg::TX_IDLE;
        end
      endcase
    end
  end
  assign TX_STROBE = tx_pend;
  assign TX_ID = tx_pend ? `CMD_FRAME_ID : 29'h0;
  assign TX_EXT = tx_pend;
  assign TX_DLC = tx_pend ? 4'h8 : 4'h0;
  assign TX_DATA = {56'h0, tx_code_reg};

  // ---------------- Receive supervision ----------------
  logic [31:0] rx_quiet_reg; // Cycles since last report
  logic rx_alive_reg; // Reports arriving in time
  wire rx_expire = rx_alive_reg && rx_quiet_reg == 32'(RX_TIMEOUT_CYC - 1) && !res.new_frame;
  assign RX_READY = 1'b1;
  // Silence timer, restarted by each accepted report
  always_ff @(posedge REF_CLK) begin
    if (RST || restart_reg) begin
      rx_quiet_reg <= 32'h0;
      rx_alive_reg <= 1'b0;
    end else if (res.new_frame) begin
      rx_quiet_reg <= 32'h0;
      rx_alive_reg <= 1'b1;
    end else if (rx_expire) begin
      rx_alive_reg <= 1'b0;
    end else if (rx_alive_reg) begin
      rx_quiet_reg <= rx_quiet_reg + 32'h1;
    end
  end

  // ---------------- Events and interrupt ----------------
  wire [`EV_WIDTH-1:0] ev_set = {tx_expire, rx_expire, res.new_frame};
  wire [`EV_WIDTH-1:0] ev_clr = wr_sts ? wr_bits[`EV_WIDTH-1:0] : '0;
  wire [`EV_WIDTH-1:0] sts_next = (sts_reg & ~ev_clr) | ev_set;
  // Sticky events; a new event wins over a same-cycle clear
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sts_reg <= '0;
    end else begin
      sts_reg <= sts_next;
    end
  end
  assign IRQ = |(sts_reg & mask_reg);

  // ---------------- AXI4-Lite read path ----------------
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic rresp_err_reg;
  assign S_AXI_ARREADY = !rvalid_reg;
  wire rd_take = S_AXI_ARVALID && S_AXI_ARREADY; // Read address taken this cycle
  wire [31:0] rd_stat_a = res.stat[31:0];
  wire [31:0] rd_stat_b = res.stat[63:32];
  wire [31:0] rd_mux =
    S_AXI_ARADDR == `OFS_CTRL ? ctrl_reg :
    S_AXI_ARADDR == `OFS_STATUS ? {29'h0, sts_reg} :
    S_AXI_ARADDR == `OFS_MASK ? {29'h0, mask_reg} :
    S_AXI_ARADDR == `OFS_READINGS ? {res.o2_raw, res.nox_raw} :
    S_AXI_ARADDR == `OFS_STAT_A ? rd_stat_a :
    S_AXI_ARADDR == `OFS_STAT_B ? rd_stat_b :
    S_AXI_ARADDR == `OFS_LINK ? {31'h0, rx_alive_reg} : 32'h0;
  wire rd_known = S_AXI_ARADDR <= `OFS_LINK && S_AXI_ARADDR[1:0] == 2'b00;
  // Read capture and response
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_err_reg <= 1'b0;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_err_reg <= !rd_known;
    end else if (S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_err_reg ? egs_link_pkg::RESP_SLVERR : egs_link_pkg::RESP_OKAY;

  // ---------------- Checks ----------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_bit_tick_spacing: assert property (BIT_TICK |=> !BIT_TICK [*8])
    else $error("bit enable too frequent");
  a_rx_timeout_flag: assert property (rx_expire |=> sts_reg[`EV_RX_TIMEOUT] && !rx_alive_reg)
    else $error("receive timeout not flagged");
  a_tx_wait_bound: assert property (tx_pend |-> tx_wait_reg < 32'(TX_TIMEOUT_CYC))
    else $error("command strobe held past timeout");
  a_rx_take_all: assert property (RX_VALID |-> RX_READY)
    else $error("frame refused");
  a_tx_id_fixed: assert property (TX_STROBE |-> TX_ID == `CMD_FRAME_ID && TX_EXT)
    else $error("wrong command identifier");
  a_heat_on_cmd: assert property ($rose(TX_STROBE) && $past(heater_req) |-> TX_DATA[7:0] == 8'h01)
    else $error("heater-on request not sent");
  a_preheat_cmd: assert property ($rose(TX_STROBE) && !$past(heater_req) |-> TX_DATA[7:0] == 8'h00)
    else $error("preheat request not sent");
  a_tx_quiet_data: assert property (!TX_STROBE |-> TX_DATA == 64'h0 && TX_ID == 29'h0)
    else $error("payload shown without strobe");
  a_restart_pulse: assert property (wr_ctrl && wr_bits[`CTRL_RESTART] |=> CHAN_RESTART ##1 !CHAN_RESTART && !TX_STROBE)
    else $error("restart pulse malformed");
  a_status_mirror: assert property (rd_take && S_AXI_ARADDR == `OFS_STAT_A |=>
    S_AXI_RDATA == $past(res.stat[31:0]))
    else $error("status word not returned on read");
endmodule

// >>> tb/sensor_ctrl_model.sv
// Behavioural model of the sensor controller and its frame-level bus controller
// Assumes the calls to send_frame are made just after a rising clk edge
`timescale 1ns/1ps
module sensor_ctrl_model (
  input wire logic clk,
  input wire logic stall,
  input wire logic tx_strobe,
  output logic tx_ready,
  input wire logic [28:0] tx_id,
  input wire logic tx_ext,
  input wire logic [3:0] tx_dlc,
  input wire logic [63:0] tx_data,
  input wire logic chan_restart,
  input wire logic bit_tick,
  output logic rx_valid,
  output logic [28:0] rx_id,
  output logic rx_ext,
  output logic [63:0] rx_data
);
  int tx_count = 0; // Command frames taken
  int restarts = 0; // Channel restart pulses seen
  int since = 0; // Cycles since the last bit tick
  int tick_gap = 0; // Spacing of the last two bit ticks
  logic [28:0] last_id = '0; // Identifier of the last command frame
  logic [4:0] last_hdr = '0; // Extended flag and length of the last command frame
  logic [7:0] last_cmd = '0; // Heater code of the last command frame
  // A stalled controller refuses command frames, so they time out
  assign tx_ready = !stall;
  initial begin
    rx_valid = 1'b0;
    rx_id = '0;
    rx_ext = 1'b0;
    rx_data = '0;
  end
  // Capture taken frames, restart pulses and the bit rate spacing
  always @(posedge clk) begin
    if (tx_strobe && tx_ready) begin
      tx_count <= tx_count + 1;
      last_id <= tx_id;
      last_hdr <= {tx_ext, tx_dlc};
      last_cmd <= tx_data[7:0];
    end
    if (chan_restart) begin
      restarts <= restarts + 1;
    end
    if (bit_tick) begin
      tick_gap <= since + 1;
      since <= 0;
    end else begin
      since <= since + 1;
    end
  end
  // One result frame beat; the lines then show a changed pattern, not the old frame
  task automatic send_frame(input logic [28:0] id, input logic ext, input logic [63:0] d);
    rx_id <= id;
    rx_ext <= ext;
    rx_data <= d;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_id <= ~id;
    rx_ext <= ~ext;
    rx_data <= ~d;
  endtask
endmodule

// >>> tb/exhaust_gas_sensor_can_link_test.sv
// Self-checking testbench of the sensor link core
// Assumes the designer's register map and a frame-level sensor controller model
`timescale 1ns/1ps
`include "egs_link_regs.svh"
module exhaust_gas_sensor_can_link_test;
  localparam logic [31:0] CMD_WORD = 32'h38fedf00; // Command identifier as printed
  localparam logic [31:0] REP_WORD = 32'h38f00f52; // Report identifier as printed
  typedef struct {logic [7:0] addr; logic [31:0] data; logic [1:0] resp;} row_type;
  logic REF_CLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, stall;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, BIT_TICK, CHAN_RESTART, IRQ;
  logic TX_STROBE, TX_EXT, RX_VALID, RX_READY, RX_EXT;
  logic [7:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, d;
  logic [1:0] BRESP, RRESP, r;
  logic [28:0] TX_ID, RX_ID;
  logic [3:0] TX_DLC;
  logic [63:0] TX_DATA, RX_DATA;
  logic u_model_ready; // Command acceptance from the model
  int fails = 0;
  int checked = 0;
  int n;
  int c;
  // Readback after one accepted report: readings, statuses, link, reset values, a hole
  row_type rows [8] = '{
    '{`OFS_READINGS, 32'habcd1234, 2'b00},
    '{`OFS_STAT_A, 32'h03020100, 2'b00},
    '{`OFS_STAT_B, 32'h03020100, 2'b00},
    '{`OFS_LINK, 32'h0000_0001, 2'b00},
    '{`OFS_STATUS, 32'h0000_0001, 2'b00},
    '{`OFS_MASK, 32'h0000_0000, 2'b00},
    '{`OFS_CTRL, 32'h0000_0000, 2'b00},
    '{8'h1c, 32'h0000_0000, 2'b10}
  };
  exhaust_gas_sensor_can_link #(.RX_TIMEOUT_CYC(200), .CMD_PERIOD_CYC(100)) u_dut (
    .REF_CLK(REF_CLK), .RST(RST),
    .S_AXI_AWADDR(AWADDR), .S_AXI_AWVALID(AWVALID), .S_AXI_AWREADY(AWREADY),
    .S_AXI_WDATA(WDATA), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(WVALID), .S_AXI_WREADY(WREADY),
    .S_AXI_BRESP(BRESP), .S_AXI_BVALID(BVALID), .S_AXI_BREADY(BREADY),
    .S_AXI_ARADDR(ARADDR), .S_AXI_ARVALID(ARVALID), .S_AXI_ARREADY(ARREADY),
    .S_AXI_RDATA(RDATA), .S_AXI_RRESP(RRESP), .S_AXI_RVALID(RVALID), .S_AXI_RREADY(RREADY),
    .BIT_TICK(BIT_TICK), .CHAN_RESTART(CHAN_RESTART), .TX_STROBE(TX_STROBE),
    .TX_READY(u_model_ready), .TX_ID(TX_ID), .TX_EXT(TX_EXT), .TX_DLC(TX_DLC),
    .TX_DATA(TX_DATA), .RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_ID(RX_ID),
    .RX_EXT(RX_EXT), .RX_DATA(RX_DATA), .IRQ(IRQ)
  );
  sensor_ctrl_model u_model (
    .clk(REF_CLK), .stall(stall), .tx_strobe(TX_STROBE), .tx_ready(u_model_ready),
    .tx_id(TX_ID), .tx_ext(TX_EXT), .tx_dlc(TX_DLC), .tx_data(TX_DATA),
    .chan_restart(CHAN_RESTART), .bit_tick(BIT_TICK), .rx_valid(RX_VALID),
    .rx_id(RX_ID), .rx_ext(RX_EXT), .rx_data(RX_DATA)
  );
  // 250 MHz clock
  initial begin
    REF_CLK = 1'b0;
    forever #2 REF_CLK = ~REF_CLK;
  end
  // Prints the counts and the verdict, then ends the run
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Compares a seen value with the expected one
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      fails++;
    end
  endtask
  // A wait that ran out counts as a mismatch and ends the run
  task automatic timed_out();
    $display("ERROR at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
    fails++;
    results();
  endtask
  // One AXI4-Lite write; address and data released each on its own handshake
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit aw;
    bit w;
    bit b;
    int k;
    aw = 0;
    w = 0;
    b = 0;
    @(posedge REF_CLK); // Let an edge pass between transfers
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (k = 0; k < 50 && !b; k++) begin
      @(posedge REF_CLK);
      if (!aw && AWREADY === 1'b1) begin
        aw = 1;
        AWVALID <= 1'b0;
      end
      if (!w && WREADY === 1'b1) begin
        w = 1;
        WVALID <= 1'b0;
      end
      if (BVALID === 1'b1) begin
        b = 1;
        rs = BRESP;
        BREADY <= 1'b0;
      end
    end
    if (!b) timed_out();
  endtask
  // One AXI4-Lite read
  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    bit ar;
    bit got;
    int k;
    ar = 0;
    got = 0;
    @(posedge REF_CLK); // Let an edge pass between transfers
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (k = 0; k < 50 && !got; k++) begin
      @(posedge REF_CLK);
      if (!ar && ARREADY === 1'b1) begin
        ar = 1;
        ARVALID <= 1'b0;
      end
      if (RVALID === 1'b1) begin
        got = 1;
        v = RDATA;
        rs = RRESP;
        RREADY <= 1'b0;
      end
    end
    if (!got) timed_out();
  endtask
  // Waits for the next command frame taken by the controller model
  task automatic next_frame();
    int k;
    c = u_model.tx_count;
    for (k = 0; k < 400 && u_model.tx_count == c; k++) @(posedge REF_CLK);
    if (u_model.tx_count == c) timed_out();
  endtask
  // Main sequence
  initial begin
    RST = 1'b1;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, stall} = '0;
    AWADDR = '0;
    ARADDR = '0;
    WDATA = '0;
    repeat (2) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    // Report frame, then the readback table
    u_model.send_frame(REP_WORD[28:0], 1'b1, 64'h0000_e4e4_abcd_1234);
    repeat (3) @(posedge REF_CLK);
    foreach (rows[i]) begin
      axi_read(rows[i].addr, d, r);
      check({r, d}, {rows[i].resp, rows[i].data});
    end
    // Wrong identifier and standard-format frames leave the readings alone
    u_model.send_frame(REP_WORD[28:0] ^ 29'h1, 1'b1, 64'h1111);
    @(posedge REF_CLK);
    u_model.send_frame(REP_WORD[28:0], 1'b0, 64'h2222);
    repeat (3) @(posedge REF_CLK);
    axi_read(`OFS_READINGS, d, r);
    check(d, 32'habcd1234);
    check(RX_READY, 1'b1);
    // Silence past the receive limit sets the timeout event and drops the link
    repeat (250) @(posedge REF_CLK);
    axi_read(`OFS_STATUS, d, r);
    check(d[1], 1'b1);
    axi_read(`OFS_LINK, d, r);
    check(d[0], 1'b0);
    // Heater on, then preheat, each in a command frame
    for (int i = 0; i < 2; i++) begin
      axi_write(`OFS_CTRL, {31'h0, i == 0}, r);
      repeat (2) @(posedge REF_CLK);
      next_frame();
      check(u_model.last_cmd, i == 0 ? egs_link_pkg::HEATER_ON : egs_link_pkg::HEATER_PREHEAT);
      check(u_model.last_id, CMD_WORD[28:0]);
      check(u_model.last_hdr, 5'h18);
    end
    // Channel restart gives one pulse and reads back zero
    n = u_model.restarts;
    axi_write(`OFS_CTRL, 32'h0000_0002, r);
    repeat (3) @(posedge REF_CLK);
    check(64'(u_model.restarts), 64'(n + 1));
    axi_read(`OFS_CTRL, d, r);
    check(d, 32'h0);
    // Refused command frame times out; mask, write-zero and clear on the interrupt
    stall <= 1'b1;
    for (n = 0; n < 400 && TX_STROBE !== 1'b1; n++) @(posedge REF_CLK);
    repeat (3) @(posedge REF_CLK);
    stall <= 1'b0;
    axi_read(`OFS_STATUS, d, r);
    check(d[2], 1'b1);
    check(IRQ, 1'b0);
    axi_write(`OFS_MASK, 32'h0000_0004, r);
    @(posedge REF_CLK);
    check(IRQ, 1'b1);
    axi_write(`OFS_STATUS, 32'h0, r);
    check(r, 2'b00);
    @(posedge REF_CLK);
    check(IRQ, 1'b1);
    axi_write(`OFS_STATUS, 32'h0000_0004, r);
    @(posedge REF_CLK);
    check(IRQ, 1'b0);
    // Unmapped write is refused with an error response
    axi_write(8'h1c, 32'h0, r);
    check(r, 2'b10);
    // Bit tick spacing gives the bus bit rate; two ticks must pass after the restart
    repeat (2100) @(posedge REF_CLK);
    check(64'(u_model.tick_gap), 64'(`BIT_DIV));
    // Reset in mid-run clears readings, strobe, interrupt and restart pulse
    RST <= 1'b1;
    repeat (2) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    check({TX_STROBE, IRQ, CHAN_RESTART}, 3'b000);
    axi_read(`OFS_READINGS, d, r);
    check(d, 32'h0);
    results();
  end
endmodule
